// [rtl/vei_redirect.sv]
// Purpose: handler pointer, claim capture, fast redirect and wake logic
// Assumes: sources, enables and core enables are synchronous to ref_clk
// Notes:   FAST_REDIRECT selects hardware capture with vector table lookup
`timescale 1ns/1ps

module vei_redirect
  import vei_pkg::*;
#(
  parameter bit FAST_REDIRECT = 1'b0
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic [NUM_SRC-1:0]       srcReq,
  input  wire logic [NUM_SRC-1:0]       srcEnable,
  input  wire logic [NUM_SRC*PRI_W-1:0] srcPriority,
  input  wire logic                     csrWrEn,
  input  wire logic                     csrRdEn,
  input  wire logic [11:0]              csrAddr,
  input  wire logic [31:0]              csrWrData,
  output logic      [31:0]              csrRdData,
  input  wire logic                     globalIe,
  input  wire logic                     extIe,
  output logic                          extIntPending,
  output logic                          wakeup,
  output logic                          stdExtTrapBypass,
  output logic                          decodeStall,
  output logic                          lsuBubbleValid,
  output logic      [31:0]              lsuBubbleAddr,
  input  wire logic                     lsuRspValid,
  input  wire logic [31:0]              lsuRspData,
  input  wire logic [1:0]               lsuRspErr,
  output logic                          fetchRedirect,
  output logic      [31:0]              redirectPc,
  output logic                          globalIeClear,
  output logic                          nmiValid,
  output logic      [31:0]              nmiCause
);

  logic [BASE_W-1:0] tableBase_reg;
  logic [ID_W-1:0]   claimId_reg;
  logic [PRI_W-1:0]  claimPri_reg;
  logic [PRI_W-1:0]  curPri_reg;
  logic [PRI_W-1:0]  threshold_reg;
  logic [ID_W-1:0]   evalId_reg;
  logic [PRI_W-1:0]  evalPri_reg;
  logic [31:0]       csrRdData_reg;
  logic              extIntPending_reg;
  logic              wakeup_reg;
  logic              decodeStall_reg;
  logic              lsuBubbleValid_reg;
  logic              fetchRedirect_reg;
  logic [31:0]       redirectPc_reg;
  logic              globalIeClear_reg;
  logic              nmiValid_reg;
  logic [31:0]       nmiCause_reg;
  vei_state_t        state_reg;
  vei_state_t        state_next;

  // evaluation: strict greater keeps the lowest id on equal priority
  logic [ID_W-1:0]  bestId;
  logic [PRI_W-1:0] bestPri;
  always_comb begin
    bestId  = '0;
    bestPri = PRI_RESET;
    for (int i = 1; i < NUM_SRC; i++) begin
      if (srcReq[i] && srcEnable[i] && (srcPriority[i*PRI_W +: PRI_W] > bestPri)) begin
        bestPri = srcPriority[i*PRI_W +: PRI_W];
        bestId  = ID_W'(i);
      end
    end
  end

  // two registered stages, evaluation then pending, keep source-to-core latency short
  wire logic [PRI_W-1:0] maxThreshold = (threshold_reg > curPri_reg) ? threshold_reg : curPri_reg;
  wire logic             overThreshold = evalPri_reg > maxThreshold;
  wire logic             bothEnables   = globalIe && extIe;

  // handler pointer: base, id shifted by two zero bits
  wire logic [31:0] handlerPtr = {tableBase_reg, claimId_reg, {PTR_PAD_W{1'b0}}};

  // register address decode, shared by write strobes and read select
  wire logic selBase    = csrAddr == CSR_TABLE_BASE;
  wire logic selPointer = csrAddr == CSR_POINTER;
  wire logic selCapture = csrAddr == CSR_CAPTURE;
  wire logic selCpri    = csrAddr == CSR_CLAIM_PRI;
  wire logic selCurPri  = csrAddr == CSR_CUR_PRI;
  wire logic selThresh  = csrAddr == CSR_THRESHOLD;

  wire logic wrBase   = csrWrEn && selBase;
  wire logic wrCpri   = csrWrEn && selCpri;
  wire logic wrCurPri = csrWrEn && selCurPri;
  wire logic wrThresh = csrWrEn && selThresh;
  wire logic fwCapture = !FAST_REDIRECT && csrWrEn && selCapture;
  wire logic hwCapture = FAST_REDIRECT && (state_reg == VEI_IDLE) && extIntPending_reg && bothEnables;
  wire logic capture   = fwCapture || hwCapture;

  wire logic [31:0] rdMux =
    selBase    ? {tableBase_reg, {BASE_LSB{1'b0}}} :
    selPointer ? handlerPtr :
    selCpri    ? {{(32-PRI_W){1'b0}}, claimPri_reg} :
    selCurPri  ? {{(32-PRI_W){1'b0}}, curPri_reg} :
    selThresh  ? {{(32-PRI_W){1'b0}}, threshold_reg} :
    WORD_ZERO;

  wire logic lookupDone = (state_reg == VEI_WAIT) && lsuRspValid;
  wire logic lookupOk   = lookupDone && (lsuRspErr == RSP_OK);
  wire logic lookupFail = lookupDone && (lsuRspErr != RSP_OK);

  wire logic [31:0] failCause =
    (lsuRspErr == RSP_ECC)     ? NMI_CAUSE_ECC :
    (lsuRspErr == RSP_PARTIAL) ? NMI_CAUSE_PARTIAL :
    NMI_CAUSE_OUTSIDE;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      VEI_IDLE:     if (hwCapture) begin
        state_next = VEI_CAPTURED;
      end
      VEI_CAPTURED: state_next = VEI_LOOKUP;
      VEI_LOOKUP:   state_next = VEI_WAIT;
      VEI_WAIT:     if (lsuRspValid) begin
        state_next = VEI_IDLE;
      end
    endcase
  end

  // next values of the registered state
  wire logic [BASE_W-1:0] tableBase_next  = wrBase ? csrWrData[31:BASE_LSB] : tableBase_reg;
  wire logic [PRI_W-1:0]  curPri_next     = wrCurPri ? csrWrData[PRI_W-1:0] : curPri_reg;
  wire logic [PRI_W-1:0]  threshold_next  = wrThresh ? csrWrData[PRI_W-1:0] : threshold_reg;
  wire logic [31:0]       csrRdData_next  = csrRdEn ? rdMux : csrRdData_reg;
  wire logic [31:0]       redirectPc_next = lookupOk ? lsuRspData : redirectPc_reg;
  wire logic [31:0]       nmiCause_next   = lookupFail ? failCause : nmiCause_reg;
  wire logic              wakeup_next     = (evalPri_reg == PRI_WAKE) && bothEnables;

  // firmware capture is unconditional on thresholds and enables; id may be zero
  wire logic [ID_W-1:0]  claimId_next  = capture ? evalId_reg : claimId_reg;
  wire logic [PRI_W-1:0] claimPri_next = capture ? evalPri_reg :
                                         wrCpri ? csrWrData[PRI_W-1:0] : claimPri_reg;

  // evaluation stage: winner id
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evalId_reg <= '0;
    end else begin
      evalId_reg <= bestId;
    end
  end

  // evaluation stage: winner priority
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evalPri_reg <= PRI_RESET;
    end else begin
      evalPri_reg <= bestPri;
    end
  end

  // vector table base
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tableBase_reg <= '0;
    end else begin
      tableBase_reg <= tableBase_next;
    end
  end

  // current priority level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      curPri_reg <= PRI_RESET;
    end else begin
      curPri_reg <= curPri_next;
    end
  end

  // priority threshold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_reg <= PRI_RESET;
    end else begin
      threshold_reg <= threshold_next;
    end
  end

  // captured id
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      claimId_reg <= '0;
    end else begin
      claimId_reg <= claimId_next;
    end
  end

  // captured priority, capture wins over a write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      claimPri_reg <= PRI_RESET;
    end else begin
      claimPri_reg <= claimPri_next;
    end
  end

  // read data, held until the next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csrRdData_reg <= WORD_ZERO;
    end else begin
      csrRdData_reg <= csrRdData_next;
    end
  end

  // pending level to the core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extIntPending_reg <= 1'b0;
    end else begin
      extIntPending_reg <= overThreshold;
    end
  end

  // wake request to the core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_reg <= 1'b0;
    end else begin
      wakeup_reg <= wakeup_next;
    end
  end

  // fast redirect sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= VEI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // decode held off for the whole lookup
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      decodeStall_reg <= 1'b0;
    end else begin
      decodeStall_reg <= state_next != VEI_IDLE;
    end
  end

  // one-cycle load/store bubble
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsuBubbleValid_reg <= 1'b0;
    end else begin
      lsuBubbleValid_reg <= state_next == VEI_LOOKUP;
    end
  end

  // flush and redirect pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchRedirect_reg <= 1'b0;
    end else begin
      fetchRedirect_reg <= lookupOk;
    end
  end

  // handler address, held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      redirectPc_reg <= WORD_ZERO;
    end else begin
      redirectPc_reg <= redirectPc_next;
    end
  end

  // global enable clear with the redirect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalIeClear_reg <= 1'b0;
    end else begin
      globalIeClear_reg <= lookupOk;
    end
  end

  // failed lookup pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiValid_reg <= 1'b0;
    end else begin
      nmiValid_reg <= lookupFail;
    end
  end

  // failure cause, held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiCause_reg <= WORD_ZERO;
    end else begin
      nmiCause_reg <= nmiCause_next;
    end
  end

  assign csrRdData        = csrRdData_reg;
  assign extIntPending    = extIntPending_reg;
  assign wakeup           = wakeup_reg;
  assign stdExtTrapBypass = FAST_REDIRECT;
  assign decodeStall      = decodeStall_reg;
  assign lsuBubbleValid   = lsuBubbleValid_reg;
  assign lsuBubbleAddr    = handlerPtr;
  assign fetchRedirect    = fetchRedirect_reg;
  assign redirectPc       = redirectPc_reg;
  assign globalIeClear    = globalIeClear_reg;
  assign nmiValid         = nmiValid_reg;
  assign nmiCause         = nmiCause_reg;

endmodule : vei_redirect

// [rtl/vei_pkg.sv]
// Purpose: constants and types for the vectored external interrupt redirect block
// Assumes: 255 sources with ids 1..255, 4-bit priorities, regular priority order
// Notes:   control registers sit in the core's control register space
package vei_pkg;

  localparam int NUM_SRC   = 256;
  localparam int PRI_W     = 4;
  localparam int ID_W      = 8;
  localparam int BASE_W    = 22;
  localparam int BASE_LSB  = 10;
  localparam int PTR_PAD_W = 2;

  localparam logic [11:0] CSR_TABLE_BASE = 12'h0bc8;
  localparam logic [11:0] CSR_POINTER    = 12'h0fc8;
  localparam logic [11:0] CSR_CAPTURE    = 12'h0bca;
  localparam logic [11:0] CSR_CLAIM_PRI  = 12'h0bcb;
  localparam logic [11:0] CSR_CUR_PRI    = 12'h0bcc;
  localparam logic [11:0] CSR_THRESHOLD  = 12'h0bc9;

  localparam logic [PRI_W-1:0] PRI_WAKE  = 4'h0f;
  localparam logic [PRI_W-1:0] PRI_RESET = 4'h0;
  localparam logic [31:0]      WORD_ZERO = 32'h0000_0000;

  localparam logic [31:0] NMI_CAUSE_ECC     = 32'hf000_1000;
  localparam logic [31:0] NMI_CAUSE_PARTIAL = 32'hf000_1001;
  localparam logic [31:0] NMI_CAUSE_OUTSIDE = 32'hf000_1002;

  localparam logic [1:0] RSP_OK      = 2'h0;
  localparam logic [1:0] RSP_ECC     = 2'h1;
  localparam logic [1:0] RSP_PARTIAL = 2'h2;
  localparam logic [1:0] RSP_OUTSIDE = 2'h3;

  typedef enum logic [1:0] {
    VEI_IDLE,
    VEI_CAPTURED,
    VEI_LOOKUP,
    VEI_WAIT
  } vei_state_t;

endpackage : vei_pkg

// [sim/vei_redirect_checker.sv]
// Purpose: port assertions for the redirect block
// Assumes: one clock domain, rst_n active low
// Notes:   bound to every vei_redirect instance
`timescale 1ns/1ps

module vei_redirect_checker
  import vei_pkg::*;
#(
  parameter bit FAST_REDIRECT = 1'b0
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        globalIe,
  input wire logic        extIe,
  input wire logic        extIntPending,
  input wire logic        wakeup,
  input wire logic        stdExtTrapBypass,
  input wire logic        decodeStall,
  input wire logic        lsuBubbleValid,
  input wire logic [31:0] lsuBubbleAddr,
  input wire logic        lsuRspValid,
  input wire logic [31:0] lsuRspData,
  input wire logic [1:0]  lsuRspErr,
  input wire logic        fetchRedirect,
  input wire logic [31:0] redirectPc,
  input wire logic        globalIeClear,
  input wire logic        nmiValid,
  input wire logic [31:0] nmiCause
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // lookup issued and not yet answered
  logic rspWait_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rspWait_reg <= 1'b0;
    else if (lsuBubbleValid) rspWait_reg <= 1'b1;
    else if (lsuRspValid) rspWait_reg <= 1'b0;
  end

  property p_ptr_align; lsuBubbleValid |-> lsuBubbleAddr[1:0] == 2'b00; endproperty
  a_ptr_align: assert property (p_ptr_align) else $error("pointer low bits set");
  property p_capture; extIntPending && globalIe && extIe && !decodeStall |-> ##[1:2] decodeStall; endproperty
  a_capture: assert property (p_capture) else $error("no capture");
  property p_stall; $rose(decodeStall) |=> lsuBubbleValid; endproperty
  a_stall: assert property (p_stall) else $error("no bubble after stall");
  property p_bubble; lsuBubbleValid |=> !lsuBubbleValid && decodeStall; endproperty
  a_bubble: assert property (p_bubble) else $error("bubble not a pulse");
  property p_redirect;
    rspWait_reg && lsuRspValid && lsuRspErr == RSP_OK
      |=> fetchRedirect && !nmiValid && !decodeStall && redirectPc == $past(lsuRspData);
  endproperty
  a_redirect: assert property (p_redirect) else $error("bad redirect");
  property p_nmi;
    rspWait_reg && lsuRspValid && lsuRspErr != RSP_OK
      |=> nmiValid && !fetchRedirect && nmiCause == NMI_CAUSE_ECC + 32'($past(lsuRspErr)) - 32'h0000_0001;
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi");
  property p_ieclear; globalIeClear == fetchRedirect; endproperty
  a_ieclear: assert property (p_ieclear) else $error("enable clear mismatch");
  property p_bypass; stdExtTrapBypass == FAST_REDIRECT; endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_wake; wakeup |-> $past(globalIe && extIe); endproperty
  a_wake: assert property (p_wake) else $error("wake without enables");
endmodule : vei_redirect_checker

bind vei_redirect vei_redirect_checker #(.FAST_REDIRECT(FAST_REDIRECT)) chk (.*);

// [sim/vei_lookup_model.sv]
// Purpose: vector table read path model
// Assumes: entry value is the inverted pointer
// Notes:   idle data toggles every cycle
`timescale 1ns/1ps

module vei_lookup_model (
  input  wire logic        ref_clk,
  input  wire logic        lsuBubbleValid,
  input  wire logic [31:0] lsuBubbleAddr,
  input  wire logic [1:0]  errMode,
  input  wire logic [2:0]  rspDelay,
  output logic             lsuRspValid,
  output logic      [31:0] lsuRspData,
  output logic      [1:0]  lsuRspErr
);
  initial lsuRspValid = 1'b0;
  initial lsuRspData = 32'h0000_0000;
  initial lsuRspErr = 2'h0;
  always @(posedge ref_clk) begin
    lsuRspValid <= 1'b0;
    lsuRspErr   <= 2'h0;
    lsuRspData  <= ~lsuRspData;
    if (lsuBubbleValid) begin
      repeat (rspDelay) @(posedge ref_clk);
      lsuRspValid <= 1'b1;
      lsuRspData  <= ~lsuBubbleAddr;
      lsuRspErr   <= errMode;
    end
  end
endmodule : vei_lookup_model

// [sim/vei_redirect_test.sv]
// Purpose: self-checking bench for fast redirect
// Assumes: inputs change at the falling edge
// Notes:   vector entry is the inverted pointer
`timescale 1ns/1ps

module vei_redirect_test
  import vei_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, csrWrEn = 0, csrRdEn = 0, globalIe = 0, extIe = 0;
  logic [NUM_SRC-1:0] srcReq = '0, srcEnable = '1;
  logic [NUM_SRC*PRI_W-1:0] srcPriority = '0;
  logic [11:0] csrAddr = '0;
  logic [31:0] csrWrData = '0, csrRdData, lsuBubbleAddr, lsuRspData, redirectPc, nmiCause;
  logic extIntPending, wakeup, stdExtTrapBypass, decodeStall, lsuBubbleValid, lsuRspValid;
  logic fetchRedirect, globalIeClear, nmiValid;
  logic [1:0] lsuRspErr, errMode = 0;
  logic [2:0] rspDelay = 0;
  int fails = 0, checked = 0;

  always #5 ref_clk = ~ref_clk;
  vei_redirect #(.FAST_REDIRECT(1'b1)) uut (.*);
  vei_lookup_model model (.*);

  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    csrAddr = a;
    csrWrData = d;
    csrWrEn = wr;
    csrRdEn = !wr;
    @(negedge ref_clk);
    csrWrEn = 0;
    csrRdEn = 0;
    if (!wr) chk(csrRdData, exp);
    @(negedge ref_clk);
  endtask : acc
  task automatic waitfor(input logic nmi);
    int n;
    n = 0;
    while ((nmi ? nmiValid : fetchRedirect) !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 40) begin
      chk(32'h0000_0000, 32'h0000_0001);
      tally_and_finish();
    end
  endtask : waitfor

  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1;
    acc(1, CSR_TABLE_BASE, 32'h1234_57ff, 0);
    acc(0, CSR_TABLE_BASE, 0, 32'h1234_5400);
    acc(0, CSR_CAPTURE, 0, 32'h0000_0000);
    acc(0, 12'h07c0, 0, 32'h0000_0000);
    chk(32'(stdExtTrapBypass), 1);
    srcPriority[12 +: 4] = 4'h9;
    srcPriority[20 +: 4] = 4'h9;
    srcPriority[800 +: 4] = 4'h4;
    srcReq[3] = 1;
    srcReq[5] = 1;
    srcReq[200] = 1;
    repeat (2) @(negedge ref_clk);
    chk(32'(extIntPending), 1);
    extIe = 1;
    globalIe = 1;
    waitfor(0);
    globalIe = 0;
    chk(redirectPc, ~32'h1234_540c);
    acc(0, CSR_POINTER, 0, 32'h1234_540c);
    acc(0, CSR_CLAIM_PRI, 0, 32'h0000_0009);
    srcEnable[3] = 0;
    repeat (2) @(negedge ref_clk);
    for (int e = 1; e < 4; e++) begin
      errMode = 2'(e);
      rspDelay = 3'(e);
      globalIe = 1;
      waitfor(1);
      globalIe = 0;
      chk(nmiCause, NMI_CAUSE_ECC + 32'(e - 1));
      acc(0, CSR_POINTER, 0, 32'h1234_5414);
    end
    acc(1, CSR_CUR_PRI, 32'h0000_0009, 0);
    repeat (2) @(negedge ref_clk);
    chk(32'(extIntPending), 0);
    acc(1, CSR_CUR_PRI, 32'h0000_0000, 0);
    errMode = 0;
    srcPriority[800 +: 4] = 4'hf;
    extIe = 0;
    globalIe = 1;
    repeat (3) @(negedge ref_clk);
    chk(32'(wakeup), 0);
    extIe = 1;
    waitfor(0);
    chk(32'(wakeup), 1);
    chk(redirectPc, ~32'h1234_5720);
    tally_and_finish();
  end
endmodule : vei_redirect_test
